//--- rtl/diag_pkg.sv
// Shared constants and carrier types for the counter diagnostic sequencer.
package diag_pkg;

    // ****************************************************************
    // Clock and timing
    // ****************************************************************
    localparam int unsigned CLK_MHZ        = 100;
    localparam int unsigned REF_OSC_MHZ    = 10;
    localparam int unsigned PORT_STEP_US   = 100000;
    localparam int unsigned PORT_STEP_CYC  = PORT_STEP_US * CLK_MHZ;
    localparam int unsigned STEP_CNT_W     = 32;

    // ****************************************************************
    // Memory sizes
    // ****************************************************************
    localparam int unsigned RAM_BYTES      = 64;
    localparam int unsigned RAM_AW         = 6;
    localparam int unsigned ROM_BYTES      = 4032;
    localparam int unsigned ROM_AW         = 12;
    localparam int unsigned SUM_W          = 16;

    // ****************************************************************
    // Remote command codes
    // ****************************************************************
    localparam logic [7:0] MEMORY_CHECK_CMD = 8'h11;
    localparam logic [7:0] BUS_ADDRESS_CMD  = 8'h12;
    localparam logic [7:0] SHORT_INTERP_CMD = 8'h13;
    localparam logic [7:0] LONG_INTERP_CMD  = 8'h14;

    // ****************************************************************
    // Calibration limits, display layout and port pattern
    // ****************************************************************
    localparam logic [7:0] CAL_LOW_BAD     = 8'h00;
    localparam logic [7:0] CAL_HIGH_BAD    = 8'hFF;
    localparam logic [8:0] CAL_MAX_DRIFT   = 9'h003;
    localparam int unsigned DISP_CHARS     = 12;
    localparam logic [7:0] CH_SPACE        = 8'h20;
    localparam logic [7:0] CH_DASH         = 8'h2D;
    localparam logic [7:0] CH_ZERO         = 8'h30;
    localparam logic [7:0] CH_ALL_ON       = 8'hFF;
    localparam logic [7:0] PORT_IDLE       = 8'hFF;
    localparam logic [2:0] PORT_BITS_M1    = 3'h7;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [1:0] {KEY_DIAG, KEY_OTHER, KEY_SEL} key_kind_t;

    typedef enum {
        R_NONE, R_REF_OSC, R_MEMORY, R_BUS_ADDR, R_SHORT_CAL, R_LONG_CAL, R_PORT
    } routine_t;

    typedef enum {M_POWERUP, M_IDLE, M_ONE_DIAG, M_DIAG, M_PORT} mode_t;

    typedef enum {MC_RAM_WR, MC_RAM_RD, MC_ROM, MC_DONE} mem_phase_t;

    typedef struct packed {
        logic       diag;
        logic       interval;
        logic       rate_b;
        logic       gate_time;
        logic       reset;
        logic       other;
    } keys_t;

    typedef struct packed {
        logic       fitted;
        logic [6:0] address;
    } bus_info_t;

    typedef struct packed {
        logic       ram_error;
        logic       rom_error;
        logic       cal_fault;
        logic       remote_error;
    } diag_flags_t;

    typedef logic [DISP_CHARS*8-1:0] disp_line_t;

endpackage

//--- rtl/diag_scratch_ram.sv
// Scratch-pad RAM under test, with registered read data.
`timescale 1ns/1ps
module diag_scratch_ram
    import diag_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              we,
    input  wire logic [RAM_AW-1:0] addr,
    input  wire logic [7:0]        wdata,
    output logic      [7:0]        rdata
);

    logic [7:0] mem [RAM_BYTES];

    // Registered read data: one cycle of latency.
    always_ff @(posedge clk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
        rdata <= mem[addr];
    end

endmodule

//--- rtl/counter_diagnostic_sequencer.sv
// Diagnostic sequencer: power-up check, key and remote selection, port walk.
`timescale 1ns/1ps
//
// What this block does
// - Two diagnose presses with nothing between enter diagnostics, starting memory check.
// - One diagnose press shows the internal 10 MHz reference frequency.
// - A selected routine repeats until another is chosen or reset key aborts.
// - Another key after one diagnose press returns to the power-up initialize state.
// - Power-up lights every display segment; remote cannot request this pattern.
// - The memory check runs while the all-segments pattern is shown.
// - A fitted remote interface is also tested during power-up.
// - Memory check writes and reads back 64 RAM bytes, flagging mismatches.
// - Memory check sums 4032 ROM bytes and compares with the stored checksum.
// - Remote codes select memory check and bus-address diagnostic.
// - Remote codes select short and long interpolator calibration checks.
// - Bus-address display shows two address digits, or two dashes if unfitted.
// - Bus-address display follows address switch changes automatically.
// - Interval key after two diagnose presses selects the bus-address diagnostic.
// - Rate-B key selects short calibration; gate-time key selects long calibration.
// - Calibration shows start and stop as three digits, four spaces apart.
// - Calibration is faulty at 000 or 255 or with drift above three.
// - Remote reads both calibration values as one repeatable 12-digit string.
// - Port test drives one low line per port, same on all four ports.
// - The low line walks least to most significant, then wraps, forever.
// - Port test starts only with strap at power-up; lasts until power cycle.
// - No key sequence or remote command reaches the port test.
module counter_diagnostic_sequencer
    import diag_pkg::*;
#(
    parameter int unsigned STEP_CYCLES = PORT_STEP_CYC,
    parameter logic [SUM_W-1:0] ROM_CHECKSUM = 16'h1234
)(
    input  wire logic              clk,
    input  wire logic              srst,
    input  wire logic              key_valid,
    input  wire keys_t             keys,
    input  wire logic              cmd_valid,
    input  wire logic [7:0]        cmd_code,
    input  wire logic              test_strap,
    input  wire bus_info_t         bus_pins,
    input  wire logic              remote_selftest_ok,
    input  wire logic              cal_valid,
    input  wire logic [7:0]        cal_start,
    input  wire logic [7:0]        cal_stop,
    input  wire logic [7:0]        rom_data,
    output logic      [ROM_AW-1:0] rom_addr,
    output disp_line_t             display,
    output logic                   ref_osc_show,
    output logic [3:0]             routine_code,
    output diag_flags_t            flags,
    output logic                   powerup_init,
    output logic [31:0]            port_lines,
    output logic [DISP_CHARS*4-1:0] remote_digits,
    output logic                   remote_digits_valid
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        mode_t                  mode;
        routine_t               routine;
        mem_phase_t             phase;
        logic [ROM_AW-1:0]      addr;
        logic [SUM_W-1:0]       sum;
        logic                   rd_pend;
        logic [RAM_AW-1:0]      rd_addr;
        diag_flags_t            flags;
        logic [1:0]             strap_sync;
        bus_info_t              bus_s1;
        bus_info_t              bus_s2;
        logic [7:0]             last_start;
        logic [7:0]             last_stop;
        logic                   have_cal;
        logic [2:0]             walk_pos;
        logic [STEP_CNT_W-1:0]  step_cnt;
        disp_line_t             display;
        logic                   ref_osc_show;
        logic                   powerup_init;
        logic [31:0]            port_lines;
        logic [DISP_CHARS*4-1:0] remote_digits;
        logic                   remote_valid;
    } state_t;

    state_t st;
    state_t next_st;
    logic [7:0] ram_rdata;
    logic       ram_we;
    logic [RAM_AW-1:0] ram_addr;
    logic [7:0] ram_wdata;

    // The RAM pattern mixes address bits so stuck address lines also miscompare.
    function automatic logic [7:0] ram_pattern(input logic [RAM_AW-1:0] a);
        ram_pattern = {a[1:0], a} ^ 8'hA5;
    endfunction

    // Three BCD digits of a byte, hundreds first.
    function automatic logic [11:0] to_bcd3(input logic [7:0] v);
        logic [7:0] h;
        logic [7:0] t;
        logic [7:0] u;
        h = v / 8'd100;
        t = (v % 8'd100) / 8'd10;
        u = v % 8'd10;
        to_bcd3 = {h[3:0], t[3:0], u[3:0]};
    endfunction

    function automatic logic [8:0] abs_diff(input logic [7:0] a, input logic [7:0] b);
        abs_diff = (a > b) ? {1'b0, a} - {1'b0, b} : {1'b0, b} - {1'b0, a};
    endfunction

    // ****************************************************************
    // Scratch RAM under test
    // ****************************************************************
    assign ram_we    = (st.phase == MC_RAM_WR) && (st.mode != M_PORT);
    assign ram_addr  = st.addr[RAM_AW-1:0];
    assign ram_wdata = ram_pattern(st.addr[RAM_AW-1:0]);

    diag_scratch_ram u_ram (
        .clk   (clk),
        .we    (ram_we),
        .addr  (ram_addr),
        .wdata (ram_wdata),
        .rdata (ram_rdata)
    );

    // ****************************************************************
    // Next-state logic
    // ****************************************************************
    always_comb begin
        logic [11:0] bs;
        logic [11:0] bp;
        logic        start_mem;
        logic        bad;
        next_st   = st;
        bs        = to_bcd3(cal_start);
        bp        = to_bcd3(cal_stop);
        start_mem = 1'b0;
        bad       = 1'b0;

        // Pin inputs cross from outside, so two flops before use.
        next_st.strap_sync = {st.strap_sync[0], test_strap};
        next_st.bus_s1     = bus_pins;
        next_st.bus_s2     = st.bus_s1;
        next_st.powerup_init = 1'b0;

        unique case (st.mode)
            M_POWERUP: begin
                // Everything lit while the memory check runs once.
                next_st.display = {DISP_CHARS{CH_ALL_ON}};
                if (st.strap_sync[1]) begin
                    next_st.mode       = M_PORT; // Strap seen only at power-up.
                    next_st.routine    = R_PORT;
                    next_st.port_lines = {4{PORT_IDLE & ~8'h01}};
                end
                if (st.phase == MC_DONE) begin
                    // A fitted interface reports its own self-test.
                    next_st.flags.remote_error = st.bus_s2.fitted && !remote_selftest_ok;
                    next_st.mode  = M_IDLE;
                end
            end
            M_IDLE: begin
                if (key_valid && keys.diag) begin
                    next_st.mode         = M_ONE_DIAG;
                    next_st.ref_osc_show = 1'b1;
                    next_st.routine      = R_REF_OSC;
                end
            end
            M_ONE_DIAG: begin
                if (key_valid && keys.diag) begin
                    next_st.mode         = M_DIAG;
                    next_st.ref_osc_show = 1'b0;
                    next_st.routine      = R_MEMORY;
                    start_mem            = 1'b1;
                end else if (key_valid) begin
                    // Any other key drops back to the initialize state.
                    next_st.mode         = M_IDLE;
                    next_st.ref_osc_show = 1'b0;
                    next_st.routine      = R_NONE;
                    next_st.powerup_init = 1'b1;
                end
            end
            M_DIAG: begin
                if (key_valid && keys.reset) begin
                    next_st.mode    = M_IDLE; // Reset key aborts.
                    next_st.routine = R_NONE;
                end else if (key_valid && keys.interval) begin
                    next_st.routine = R_BUS_ADDR;
                end else if (key_valid && keys.rate_b) begin
                    next_st.routine = R_SHORT_CAL;
                    next_st.have_cal = 1'b0;
                end else if (key_valid && keys.gate_time) begin
                    next_st.routine = R_LONG_CAL;
                    next_st.have_cal = 1'b0;
                end
            end
            M_PORT: begin
                // Nothing leaves this mode except a power cycle.
                if (st.step_cnt >= STEP_CNT_W'(STEP_CYCLES - 1)) begin
                    next_st.step_cnt = '0;
                    next_st.walk_pos = (st.walk_pos == PORT_BITS_M1) ? 3'h0
                                                                     : st.walk_pos + 3'h1;
                end else begin
                    next_st.step_cnt = st.step_cnt + STEP_CNT_W'(1);
                end
                // Same walking low on each of the four ports.
                for (int p = 0; p < 4; p++) begin
                    next_st.port_lines[p*8 +: 8] = PORT_IDLE & ~(8'h01 << next_st.walk_pos);
                end
                next_st.display = {DISP_CHARS{CH_DASH}};
            end
            default: next_st.mode = M_IDLE;
        endcase

        // Remote selection, ignored at power-up and in port test.
        if (cmd_valid && (st.mode == M_IDLE || st.mode == M_DIAG || st.mode == M_ONE_DIAG)) begin
            if (cmd_code == MEMORY_CHECK_CMD) begin
                next_st.mode = M_DIAG;
                next_st.routine = R_MEMORY;
                start_mem = 1'b1;
            end else if (cmd_code == BUS_ADDRESS_CMD) begin
                next_st.mode = M_DIAG;
                next_st.routine = R_BUS_ADDR;
            end else if (cmd_code == SHORT_INTERP_CMD || cmd_code == LONG_INTERP_CMD) begin
                next_st.mode = M_DIAG;
                next_st.routine = (cmd_code == SHORT_INTERP_CMD) ? R_SHORT_CAL : R_LONG_CAL;
                next_st.have_cal = 1'b0;
            end
            next_st.ref_osc_show = 1'b0;
        end

        // Memory check engine; repeats while the memory routine stays selected.
        if (st.phase == MC_DONE && st.mode == M_DIAG && st.routine == R_MEMORY) begin
            start_mem = 1'b1;
        end
        next_st.rd_pend = 1'b0;
        if (st.rd_pend && ram_rdata != ram_pattern(st.rd_addr)) begin
            next_st.flags.ram_error = 1'b1;
        end
        unique case (st.phase)
            MC_RAM_WR: begin
                next_st.addr = st.addr + ROM_AW'(1);
                if (st.addr == ROM_AW'(RAM_BYTES - 1)) begin
                    next_st.phase = MC_RAM_RD;
                    next_st.addr  = '0;
                end
            end
            MC_RAM_RD: begin
                next_st.rd_pend = 1'b1;
                next_st.rd_addr = st.addr[RAM_AW-1:0];
                next_st.addr    = st.addr + ROM_AW'(1);
                if (st.addr == ROM_AW'(RAM_BYTES - 1)) begin
                    next_st.phase = MC_ROM;
                    next_st.addr  = '0;
                    next_st.sum   = '0;
                end
            end
            MC_ROM: begin
                // rom_addr follows addr, so rom_data belongs to this address.
                if (st.rd_pend || st.addr != '0) begin
                    next_st.sum = st.sum + SUM_W'(rom_data);
                end
                next_st.addr = st.addr + ROM_AW'(1);
                if (st.addr == ROM_AW'(ROM_BYTES)) begin
                    next_st.phase = MC_DONE;
                    next_st.flags.rom_error = (st.sum != ROM_CHECKSUM);
                end
            end
            MC_DONE: ;
        endcase
        if (start_mem && st.phase == MC_DONE) begin
            next_st.phase = MC_RAM_WR;
            next_st.addr  = '0;
            next_st.flags.ram_error = 1'b0;
        end

        // Display per routine; bus address refreshed every cycle so switch changes show, calibration on each cal_valid.
        if (st.mode == M_DIAG && st.routine == R_BUS_ADDR) begin
            next_st.display = {CH_SPACE, CH_SPACE, "ADDRESS", CH_SPACE, CH_DASH, CH_DASH};
            if (st.bus_s2.fitted) begin
                next_st.display[15:0] = {CH_ZERO + 8'(st.bus_s2.address / 7'd10),
                                         CH_ZERO + 8'(st.bus_s2.address % 7'd10)};
            end
        end
        if (st.mode == M_DIAG && (st.routine == R_SHORT_CAL || st.routine == R_LONG_CAL)
            && cal_valid) begin
            // Start digits, four spaces, stop digits, then padding.
            next_st.display = {CH_ZERO + {4'h0, bs[11:8]}, CH_ZERO + {4'h0, bs[7:4]},
                               CH_ZERO + {4'h0, bs[3:0]}, CH_SPACE, CH_SPACE, CH_SPACE,
                               CH_SPACE, CH_ZERO + {4'h0, bp[11:8]},
                               CH_ZERO + {4'h0, bp[7:4]}, CH_ZERO + {4'h0, bp[3:0]},
                               CH_SPACE, CH_SPACE};
            bad = (cal_start == CAL_LOW_BAD) || (cal_start == CAL_HIGH_BAD) ||
                  (cal_stop == CAL_LOW_BAD) || (cal_stop == CAL_HIGH_BAD);
            if (st.have_cal && (abs_diff(cal_start, st.last_start) > CAL_MAX_DRIFT ||
                                abs_diff(cal_stop, st.last_stop) > CAL_MAX_DRIFT)) begin
                bad = 1'b1;
            end
            next_st.flags.cal_fault = bad;
            next_st.last_start = cal_start;
            next_st.last_stop  = cal_stop;
            next_st.have_cal   = 1'b1;
            // Twelve-digit string held until the next reading.
            next_st.remote_digits = {4'h0, 4'h0, 4'h0, bs, 4'h0, 4'h0, 4'h0, bp};
            next_st.remote_valid  = 1'b1;
        end
        if (!(st.mode == M_DIAG && (st.routine == R_SHORT_CAL || st.routine == R_LONG_CAL))) begin
            next_st.remote_valid = 1'b0;
        end
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (srst) begin
            st              <= '0;
            st.mode         <= M_POWERUP;
            st.routine      <= R_NONE;
            st.phase        <= MC_RAM_WR;
            st.port_lines   <= {4{PORT_IDLE}};
        end else begin
            st <= next_st;
        end
    end

    // ****************************************************************
    // Outputs, all from flops
    // ****************************************************************
    assign rom_addr            = st.addr;
    assign display             = st.display;
    assign ref_osc_show        = st.ref_osc_show;
    assign routine_code        = (st.routine == R_NONE) ? 4'h0 : 4'(st.routine);
    assign flags               = st.flags;
    assign powerup_init        = st.powerup_init;
    assign port_lines          = st.port_lines;
    assign remote_digits       = st.remote_digits;
    assign remote_digits_valid = st.remote_valid;

endmodule

//--- tb/diag_seq_props.sv
// Concurrent checks on the diagnostic sequencer ports.
`timescale 1ns/1ps
module diag_seq_props
    import diag_pkg::*;
#(
    parameter int unsigned STEP_CYCLES = 4
)(
    input wire logic        clk,
    input wire logic        srst,
    input wire logic        key_valid,
    input wire keys_t       keys,
    input wire logic        cmd_valid,
    input wire logic [7:0]  cmd_code,
    input wire disp_line_t  display,
    input wire logic        ref_osc_show,
    input wire logic [3:0]  routine_code,
    input wire logic        powerup_init,
    input wire logic [31:0] port_lines
);
    logic [12:0] up_cnt;
    logic [31:0] hold_cnt;
    logic [31:0] prev_lines;
    // Quiet span after reset covers the power-up check.
    always_ff @(posedge clk) begin
        if (srst || powerup_init) begin
            up_cnt <= 13'h0000;
        end else if (up_cnt != 13'h1130) begin
            up_cnt <= up_cnt + 13'h0001;
        end
    end
    // Cycles since the port pattern last moved.
    always_ff @(posedge clk) begin
        prev_lines <= srst ? 32'hFFFFFFFF : port_lines;
        hold_cnt   <= (srst || port_lines != prev_lines) ? 32'h0 : hold_cnt + 32'h1;
    end
    wire logic settled = up_cnt == 13'h1130;
    wire logic walking = routine_code == 4'h6 && prev_lines != 32'hFFFFFFFF;
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    // Second diagnose press while the reference frequency is shown.
    sequence s_one_diag;
        ref_osc_show && key_valid && keys == 6'h20 && !cmd_valid;
    endsequence
    property p_first_mem; s_one_diag |=> routine_code == 4'h2; endproperty
    a_first_mem: assert property (p_first_mem) else $error("no memory check");
    property p_persist;
        settled && !key_valid && !cmd_valid && routine_code inside {[4'h2:4'h5]}
            |=> $stable(routine_code);
    endproperty
    a_persist: assert property (p_persist) else $error("routine dropped");
    property p_other_key;
        ref_osc_show && key_valid && !keys.diag && !cmd_valid |=> powerup_init;
    endproperty
    a_other_key: assert property (p_other_key) else $error("no init");
    property p_starburst; $fell(srst) |-> ##[1:2] display == {DISP_CHARS{CH_ALL_ON}}; endproperty
    a_starburst: assert property (p_starburst) else $error("segments not lit");
    property p_remote_sel;
        settled && cmd_valid && cmd_code inside {[8'h11:8'h14]} && routine_code != 4'h6
            |=> routine_code == 4'($past(cmd_code) - 8'h0F);
    endproperty
    a_remote_sel: assert property (p_remote_sel) else $error("bad remote");
    property p_port_shape;
        routine_code == 4'h6 && port_lines != 32'hFFFFFFFF
            |-> $onehot(~port_lines[7:0]) && port_lines == {4{port_lines[7:0]}};
    endproperty
    a_port_shape: assert property (p_port_shape) else $error("port shape");
    property p_port_step;
        walking && port_lines != prev_lines
            |-> hold_cnt == STEP_CYCLES - 1 && port_lines[7:0] == {prev_lines[6:0], prev_lines[7]};
    endproperty
    a_port_step: assert property (p_port_step) else $error("port step");
    property p_port_hold; routine_code == 4'h6 |=> routine_code == 4'h6; endproperty
    a_port_hold: assert property (p_port_hold) else $error("port left");
endmodule
bind counter_diagnostic_sequencer diag_seq_props #(.STEP_CYCLES(STEP_CYCLES)) u_props (
    .clk, .srst, .key_valid, .keys, .cmd_valid, .cmd_code, .display,
    .ref_osc_show, .routine_code, .powerup_init, .port_lines);

//--- tb/panel_model.sv
// Front panel and remote controller stand-in issuing key presses and commands.
`timescale 1ns/1ps
module panel_model
    import diag_pkg::*;
(
    input  wire logic  clk,
    output keys_t      keys,
    output logic       key_valid,
    output logic       cmd_valid,
    output logic [7:0] cmd_code
);
    // Lines idle from time zero.
    initial begin
        keys      = '0;
        key_valid = 1'b0;
        cmd_valid = 1'b0;
        cmd_code  = 8'h00;
    end
    // One-hot key held for exactly one sampled edge.
    task automatic press(input keys_t k);
        @(posedge clk);
        key_valid <= 1'b1;
        keys      <= k;
        @(posedge clk);
        key_valid <= 1'b0;
        keys      <= '0;
    endtask
    // Remote code held for one sampled edge.
    task automatic send(input logic [7:0] c);
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_code  <= c;
        @(posedge clk);
        cmd_valid <= 1'b0;
        cmd_code  <= 8'h00;
    endtask
endmodule

//--- tb/counter_diagnostic_sequencer_tb.sv
// Self-checking bench for the counter diagnostic sequencer.
`timescale 1ns/1ps
module counter_diagnostic_sequencer_tb;
    import diag_pkg::*;
    localparam keys_t K_DIAG = 6'h20, K_INT = 6'h10, K_RATE = 6'h08;
    localparam keys_t K_GATE = 6'h04, K_RST = 6'h02, K_OTH = 6'h01;
    logic        clk, srst, key_valid, cmd_valid, test_strap, remote_selftest_ok, cal_valid;
    keys_t       keys;
    bus_info_t   bus_pins;
    logic [7:0]  cmd_code, cal_start, cal_stop, rom_data;
    logic [11:0] rom_addr;
    disp_line_t  display;
    logic        ref_osc_show, powerup_init, remote_digits_valid;
    logic [3:0]  routine_code;
    diag_flags_t flags;
    logic [31:0] port_lines;
    logic [47:0] remote_digits;
    int          err_count, checks_done;
    // ROM byte is its low address byte, so the 4032-byte sum is 0xC020.
    assign rom_data = rom_addr[7:0];
    counter_diagnostic_sequencer #(.STEP_CYCLES(4), .ROM_CHECKSUM(16'hC020)) dut (
        .clk, .srst, .key_valid, .keys, .cmd_valid, .cmd_code, .test_strap, .bus_pins,
        .remote_selftest_ok, .cal_valid, .cal_start, .cal_stop, .rom_data, .rom_addr,
        .display, .ref_osc_show, .routine_code, .flags, .powerup_init, .port_lines,
        .remote_digits, .remote_digits_valid);
    panel_model u_panel (.clk, .keys, .key_valid, .cmd_valid, .cmd_code);
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic check(input logic [95:0] seen, input logic [95:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("Checks %0d, mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic power_up(input logic strap);
        @(posedge clk);
        test_strap <= strap;
        srst       <= 1'b1;
        repeat (10) @(posedge clk);
        srst <= 1'b0;
    endtask
    task automatic sel(input keys_t k);
        u_panel.press(K_RST);
        u_panel.press(K_DIAG);
        u_panel.press(K_DIAG);
        u_panel.press(k);
        #1;
    endtask
    task automatic cal(input logic [7:0] s, input logic [7:0] e, input logic bad);
        @(posedge clk);
        cal_valid <= 1'b1;
        cal_start <= s;
        cal_stop  <= e;
        @(posedge clk);
        cal_valid <= 1'b0;
        settle(3);
        check(flags.cal_fault, bad);
    endtask
    task automatic t_powerup();
        power_up(1'b0);
        settle(2);
        check(display, {DISP_CHARS{CH_ALL_ON}});
        settle(4500);
        check(flags, 4'h0);
    endtask
    task automatic t_keys();
        u_panel.press(K_DIAG);
        #1 check({ref_osc_show, routine_code}, 5'h11);
        u_panel.press(K_OTH);
        #1 check(powerup_init, 1'b1);
        settle(4500);
        u_panel.press(K_DIAG);
        u_panel.press(K_DIAG);
        settle(200);
        check(routine_code, 4'h2);
        u_panel.press(K_RST);
        #1 check(routine_code, 4'h0);
    endtask
    task automatic t_bus();
        sel(K_INT);
        check(routine_code, 4'h3);
        settle(8);
        check(display, "  ADDRESS 03");
        @(posedge clk) bus_pins <= 8'hAD;
        settle(8);
        check(display, "  ADDRESS 45");
        @(posedge clk) bus_pins <= 8'h2D;
        settle(8);
        check(display, "  ADDRESS --");
        @(posedge clk) bus_pins <= 8'h83;
    endtask
    task automatic t_cal();
        sel(K_RATE);
        check(routine_code, 4'h4);
        cal(8'h80, 8'h81, 1'b0);
        check({remote_digits_valid, remote_digits}, 49'h1000128000129);
        check(display, "128    129  ");
        cal(8'h83, 8'h82, 1'b0);
        cal(8'h87, 8'h82, 1'b1);
        sel(K_GATE);
        check(routine_code, 4'h5);
        cal(8'h00, 8'h50, 1'b1);
        cal(8'h01, 8'h50, 1'b0);
        cal(8'h01, 8'hFF, 1'b1);
    endtask
    task automatic t_remote();
        for (int c = 8'h11; c <= 8'h14; c++) begin
            u_panel.send(8'(c));
            #1 check(routine_code, 4'(c - 8'h0F));
        end
        u_panel.send(8'h15);
        #1 check(routine_code, 4'h5);
    endtask
    task automatic t_port();
        power_up(1'b1);
        for (int i = 0; i < 50 && port_lines === 32'hFFFFFFFF; i++) settle(1);
        check(port_lines, 32'hFEFEFEFE);
        for (int i = 1; i <= 8; i++) begin
            settle(4);
            check(port_lines, {4{~(8'h01 << (i % 8))}});
        end
        u_panel.press(K_DIAG);
        u_panel.send(8'h11);
        #1 check(routine_code, 4'h6);
        power_up(1'b0);
        settle(20);
        check(port_lines, 32'hFFFFFFFF);
    endtask
    // Inputs start idle; interface fitted at address 3.
    initial begin
        srst               = 1'b1;
        test_strap         = 1'b0;
        remote_selftest_ok = 1'b1;
        bus_pins           = 8'h83;
        cal_valid          = 1'b0;
        cal_start          = 8'h00;
        cal_stop           = 8'h00;
        t_powerup();
        t_keys();
        t_bus();
        t_cal();
        t_remote();
        t_port();
        give_verdict();
    end
    // Watchdog: the sequence needs about 9400 cycles.
    initial begin
        repeat (40000) @(posedge clk);
        err_count++;
        give_verdict();
    end
endmodule
